// [hw/jtx_link_tx.sv]
// single-lane transmit link: framing, scrambling, alignment and phases
`timescale 1ns/1ps
`default_nettype none
module jtx_link_tx (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [13:0] SAMPLE_DATA,
  input wire logic SAMPLE_OVER,
  input wire logic SAMPLE_UNDER,
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  input wire logic SYNC_REQUEST_N_INPUT,
  input wire logic SYSREF,
  input wire logic SCRAMBLE_EN,
  input wire logic [1:0] TAIL_MODE,
  input wire logic [1:0] ILAS_MODE,
  input wire logic [4:0] FRAMES_PER_MF_M1,
  input wire logic [7:0] DEVICE_ID,
  input wire logic [3:0] BANK_ID,
  input wire logic [4:0] LANE_ID,
  output logic [9:0] SERIAL_LANE_OUTPUT_PAIR,
  output logic [1:0] LINK_PHASE,
  output logic [7:0] CHECKSUM,
  output logic SAMPLE_ALIGN
);

  // ----------------------------------------------------------------
  // state of the link, one octet position per clock
  // ----------------------------------------------------------------
  typedef struct packed {
    jtx_pkg::jtx_phase_t phase;
    logic [5:0] oct;
    logic [1:0] mf;
    logic [7:0] out_oct;
    logic out_k;
    logic [7:0] hold;
    logic [7:0] prev_last;
    logic [14:0] scr;
    logic [8:0] prbs;
    logic sysref_d;
    logic align;
    logic [7:0] chk;
  } jtx_state_t;

  localparam jtx_state_t RST_VAL = '{
    phase: jtx_pkg::PH_CGS,
    out_oct: jtx_pkg::K28_5,
    out_k: 1'b1,
    scr: jtx_pkg::SCR_SEED,
    prbs: jtx_pkg::PRBS_SEED,
    default: '0};

  jtx_state_t s_r, s_nxt;

  logic fifo_valid;
  logic fifo_pop;
  logic [jtx_pkg::SAMPLE_W-1:0] fifo_data;
  logic mf_end;
  logic [7:0] raw_oct;
  logic [7:0] scr_oct;
  logic [7:0] cfg_oct;
  logic [3:0] cfg_idx;
  logic [1:0] cs_val;
  logic [1:0] tail;
  logic [7:0] chk_sum;
  logic [22:0] scr_res;

  // ----------------------------------------------------------------
  // scrambler: each output bit is input ^ s(14 back) ^ s(15 back)
  // ----------------------------------------------------------------
  function automatic logic [22:0] scramble8(input logic [7:0] d,
                                            input logic [14:0] st);
    logic [7:0] o;
    logic [14:0] s;
    s = st;
    o = '0;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ s[13] ^ s[14];
      s = {s[13:0], o[i]};
    end
    return {o, s};
  endfunction

  // ----------------------------------------------------------------
  // sample buffer: holds {data, over, under} words
  // ----------------------------------------------------------------
  jtx_fifo #(
    .WIDTH(jtx_pkg::SAMPLE_W),
    .DEPTH(jtx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK_SYS),
    .rst(RESET),
    .in_valid(SAMPLE_VALID),
    .in_data({SAMPLE_DATA, SAMPLE_OVER, SAMPLE_UNDER}),
    .in_ready(SAMPLE_READY),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // ----------------------------------------------------------------
  // configuration octets and checksum
  // ----------------------------------------------------------------
  // control bit count follows the tail mode
  always_comb begin
    if (TAIL_MODE == jtx_pkg::TAIL_CTRL2) begin
      cs_val = 2'h2;
    end else if (TAIL_MODE == jtx_pkg::TAIL_CTRL1) begin
      cs_val = 2'h1;
    end else begin
      cs_val = 2'h0;
    end
  end

  // sum of the fields before packing, wraps at 256
  assign chk_sum = DEVICE_ID + 8'(BANK_ID) + 8'(LANE_ID)
    + 8'(SCRAMBLE_EN) + 8'(jtx_pkg::L_M1) + jtx_pkg::F_M1
    + 8'(FRAMES_PER_MF_M1) + jtx_pkg::M_M1 + 8'(cs_val)
    + 8'(jtx_pkg::N_M1) + 8'(jtx_pkg::SUBCLASS_VAL)
    + 8'(jtx_pkg::NP_M1) + 8'(jtx_pkg::JESDV_VAL)
    + 8'(jtx_pkg::S_M1) + 8'(jtx_pkg::HD_VAL) + 8'(jtx_pkg::CF_VAL);

  assign cfg_idx = 4'(s_r.oct - jtx_pkg::CFG_FIRST_POS);

  // octet layout of the second alignment multiframe
  always_comb begin
    case (cfg_idx)
      4'h0: cfg_oct = DEVICE_ID;
      4'h1: cfg_oct = {4'h0, BANK_ID};
      4'h2: cfg_oct = {3'h0, LANE_ID};
      4'h3: cfg_oct = {SCRAMBLE_EN, 2'h0, jtx_pkg::L_M1};
      4'h4: cfg_oct = jtx_pkg::F_M1;
      4'h5: cfg_oct = {3'h0, FRAMES_PER_MF_M1};
      4'h6: cfg_oct = jtx_pkg::M_M1;
      4'h7: cfg_oct = {cs_val, 1'b0, jtx_pkg::N_M1};
      4'h8: cfg_oct = {jtx_pkg::SUBCLASS_VAL, jtx_pkg::NP_M1};
      4'h9: cfg_oct = {jtx_pkg::JESDV_VAL, jtx_pkg::S_M1};
      4'ha: cfg_oct = {jtx_pkg::HD_VAL, 2'h0, jtx_pkg::CF_VAL};
      4'hd: cfg_oct = s_r.chk;
      default: cfg_oct = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // octet generation and phase sequencing
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    fifo_pop = 1'b0;
    raw_oct = s_r.hold;
    scr_oct = s_r.hold;
    scr_res = {s_r.hold, s_r.scr};
    tail = 2'h0;
    s_nxt.chk = chk_sum;
    // multiframe is K frames of two octets, K = field + 1
    mf_end = (s_r.oct == {FRAMES_PER_MF_M1, 1'b1});
    s_nxt.out_k = 1'b0;
    s_nxt.out_oct = {2'h0, s_r.oct};
    case (s_r.phase)
      jtx_pkg::PH_CGS: begin
        s_nxt.out_k = 1'b1;
        s_nxt.out_oct = jtx_pkg::K28_5;
      end
      jtx_pkg::PH_ILAS: begin
        // unscrambled; dummy octets carry the octet position
        if (s_r.oct == '0) begin
          s_nxt.out_k = 1'b1;
          s_nxt.out_oct = jtx_pkg::K28_0;
        end else if (mf_end) begin
          s_nxt.out_k = 1'b1;
          s_nxt.out_oct = jtx_pkg::K28_3;
        end else if (s_r.mf == 2'h1 && s_r.oct == 6'h01) begin
          s_nxt.out_k = 1'b1;
          s_nxt.out_oct = jtx_pkg::K28_4;
        end else if (s_r.mf == 2'h1 &&
                     s_r.oct >= jtx_pkg::CFG_FIRST_POS &&
                     s_r.oct <= jtx_pkg::CFG_LAST_POS) begin
          s_nxt.out_oct = cfg_oct;
        end
      end
      default: begin
        if (!s_r.oct[0]) begin
          // tail source chosen per frame
          case (TAIL_MODE)
            jtx_pkg::TAIL_PRBS: tail = s_r.prbs[1:0];
            jtx_pkg::TAIL_CTRL1: tail = {fifo_data[1] | fifo_data[0], 1'b0};
            jtx_pkg::TAIL_CTRL2: tail = {fifo_data[1] | fifo_data[0],
                                          fifo_valid};
            default: tail = 2'h0;
          endcase
          s_nxt.prbs = {s_r.prbs[7:0], s_r.prbs[8] ^ s_r.prbs[4]};
          // an empty buffer sends a zero sample rather than stalling
          raw_oct = fifo_valid ? fifo_data[15:8] : 8'h00;
          s_nxt.hold = fifo_valid ? {fifo_data[7:2], tail}
                                  : {6'h00, tail};
          fifo_pop = fifo_valid;
        end
        scr_res = scramble8(raw_oct, s_r.scr);
        if (SCRAMBLE_EN) begin
          scr_oct = scr_res[22:15];
          s_nxt.scr = scr_res[14:0];
        end else begin
          scr_oct = raw_oct;
        end
        s_nxt.out_oct = scr_oct;
        if (s_r.oct[0]) begin
          if (SCRAMBLE_EN) begin
            // the matching values already equal the control codes
            s_nxt.out_k = mf_end ? (scr_oct == jtx_pkg::K28_3)
                                 : (scr_oct == jtx_pkg::K28_7);
          end else if (scr_oct == s_r.prev_last) begin
            s_nxt.out_k = 1'b1;
            s_nxt.out_oct = mf_end ? jtx_pkg::K28_3
                                   : jtx_pkg::K28_7;
          end
          s_nxt.prev_last = scr_oct;
        end
      end
    endcase
    // position advance; a SYSREF edge restarts the multiframe
    s_nxt.oct = mf_end ? 6'h00 : s_r.oct + 6'h01;
    s_nxt.sysref_d = SYSREF;
    s_nxt.align = SYSREF && !s_r.sysref_d;
    if (SYSREF && !s_r.sysref_d) begin
      s_nxt.oct = 6'h00;
    end
    // phase changes only on multiframe boundaries, except a sync drop
    if (!SYNC_REQUEST_N_INPUT) begin
      s_nxt.phase = jtx_pkg::PH_CGS;
      s_nxt.mf = 2'h0;
    end else if (mf_end) begin
      case (s_r.phase)
        jtx_pkg::PH_CGS: begin
          s_nxt.mf = 2'h0;
          s_nxt.phase = (ILAS_MODE == jtx_pkg::ILAS_OFF)
            ? jtx_pkg::PH_DATA : jtx_pkg::PH_ILAS;
        end
        jtx_pkg::PH_ILAS: begin
          s_nxt.mf = s_r.mf + 2'h1;
          if (s_r.mf == jtx_pkg::ILAS_LAST_MF &&
              ILAS_MODE != jtx_pkg::ILAS_REPEAT) begin
            s_nxt.phase = jtx_pkg::PH_DATA;
          end
        end
        default: s_nxt.phase = jtx_pkg::PH_DATA;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_r <= RST_VAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // line coding and outputs
  // ----------------------------------------------------------------
  jtx_enc8b10b u_enc (
    .clk(CLK_SYS),
    .rst(RESET),
    .data(s_r.out_oct),
    .k(s_r.out_k),
    .symbol(SERIAL_LANE_OUTPUT_PAIR)
  );

  assign LINK_PHASE = s_r.phase;
  assign CHECKSUM = s_r.chk;
  assign SAMPLE_ALIGN = s_r.align;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_cgs_comma: assert property (
    s_r.phase == jtx_pkg::PH_CGS |=>
      s_r.out_k && s_r.out_oct == jtx_pkg::K28_5)
    else $error("sync phase did not send K28.5");

  a_sync_drop: assert property (
    !SYNC_REQUEST_N_INPUT |=> s_r.phase == jtx_pkg::PH_CGS)
    else $error("sync request low did not return to sync phase");

  a_ilas_entry: assert property (
    s_r.phase == jtx_pkg::PH_CGS && SYNC_REQUEST_N_INPUT && mf_end &&
    ILAS_MODE == jtx_pkg::ILAS_ONCE |=>
      s_r.phase == jtx_pkg::PH_ILAS && s_r.mf == 2'h0)
    else $error("alignment did not start at the multiframe boundary");

  a_ilas_frame: assert property (
    s_r.phase == jtx_pkg::PH_ILAS && s_r.oct == 6'h00 |=>
      s_r.out_k &&
      s_r.out_oct == jtx_pkg::K28_0)
    else $error("alignment multiframe did not open with K28.0");

  a_ilas_close: assert property (
    s_r.phase == jtx_pkg::PH_ILAS && mf_end |=>
      s_r.out_k && s_r.out_oct == jtx_pkg::K28_3)
    else $error("alignment multiframe did not close with K28.3");

  a_ilas_q: assert property (
    s_r.phase == jtx_pkg::PH_ILAS && s_r.mf == 2'h1 &&
    s_r.oct == 6'h01 |=> s_r.out_k && s_r.out_oct == jtx_pkg::K28_4)
    else $error("second multiframe missing K28.4");

  a_hi_octet: assert property (
    s_r.phase == jtx_pkg::PH_DATA && !s_r.oct[0] && !SCRAMBLE_EN &&
    fifo_valid |=> !s_r.out_k && s_r.out_oct == 8'($past(fifo_data) >> 8))
    else $error("first octet does not hold sample bits 13..6");

  a_lo_octet: assert property (
    s_r.phase == jtx_pkg::PH_DATA && s_r.oct[0] && !SCRAMBLE_EN |=>
      s_r.out_k || s_r.out_oct[7:2] == 6'($past(s_r.hold) >> 2))
    else $error("second octet does not hold sample bits 5..0");

  a_repl_mf: assert property (
    s_r.phase == jtx_pkg::PH_DATA && s_r.oct[0] && !SCRAMBLE_EN &&
    mf_end && s_r.hold == s_r.prev_last |=>
      s_r.out_k && s_r.out_oct == jtx_pkg::K28_3)
    else $error("repeated multiframe end octet not replaced");

  a_repl_scr: assert property (
    s_r.phase == jtx_pkg::PH_DATA && s_r.oct[0] && SCRAMBLE_EN &&
    !mf_end && scr_oct == jtx_pkg::K28_7 |=> s_r.out_k)
    else $error("scrambled 0xfc frame end not replaced");

  a_scr_hold: assert property (
    s_r.phase != jtx_pkg::PH_DATA |=> s_r.scr == $past(s_r.scr))
    else $error("scrambler advanced outside data phase");

  a_sysref_lmfc: assert property (
    SYSREF && !s_r.sysref_d |=> s_r.oct == 6'h00 && s_r.align
      ##1 !s_r.align || (SYSREF && !s_r.sysref_d))
    else $error("SYSREF edge did not restart the multiframe");

endmodule
`default_nettype wire

// [hw/jtx_pkg.sv]
// constants and types shared by the single-lane transmit link
package jtx_pkg;

  // ----------------------------------------------------------------
  // control characters (octet values sent with the k flag set)
  // ----------------------------------------------------------------
  localparam logic [7:0] K28_0 = 8'h1c;
  localparam logic [7:0] K28_3 = 8'h7c;
  localparam logic [7:0] K28_4 = 8'h9c;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_7 = 8'hfc;

  // ----------------------------------------------------------------
  // fixed link parameters; the _M1 ones already in their minus-one field form
  // ----------------------------------------------------------------
  localparam logic [4:0] L_M1 = 5'h00;
  localparam logic [7:0] F_M1 = 8'h01;
  localparam logic [7:0] M_M1 = 8'h00;
  localparam logic [4:0] N_M1 = 5'h0d;
  localparam logic [4:0] NP_M1 = 5'h0f;
  localparam logic [4:0] S_M1 = 5'h00;
  localparam logic [4:0] CF_VAL = 5'h00;
  localparam logic HD_VAL = 1'b0;
  localparam logic [2:0] SUBCLASS_VAL = 3'h1;
  localparam logic [2:0] JESDV_VAL = 3'h1;
  localparam logic [4:0] K_M1_DEFAULT = 5'h1f;

  // ----------------------------------------------------------------
  // alignment sequence layout and modes
  // ----------------------------------------------------------------
  localparam logic [1:0] ILAS_LAST_MF = 2'h3;
  localparam logic [5:0] CFG_FIRST_POS = 6'h02;
  localparam logic [5:0] CFG_LAST_POS = 6'h0f;
  localparam logic [1:0] ILAS_ONCE = 2'h0;
  localparam logic [1:0] ILAS_OFF = 2'h1;
  localparam logic [1:0] ILAS_REPEAT = 2'h2;

  // ----------------------------------------------------------------
  // tail bit modes, seeds and buffer shape
  // ----------------------------------------------------------------
  localparam logic [1:0] TAIL_ZERO = 2'h0;
  localparam logic [1:0] TAIL_PRBS = 2'h1;
  localparam logic [1:0] TAIL_CTRL1 = 2'h2;
  localparam logic [1:0] TAIL_CTRL2 = 2'h3;
  localparam logic [14:0] SCR_SEED = 15'h7f80;
  localparam logic [8:0] PRBS_SEED = 9'h1ff;
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {PH_CGS, PH_ILAS, PH_DATA} jtx_phase_t;

endpackage

// [hw/jtx_fifo.sv]
// sample buffer with registered read data and valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module jtx_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } jtx_fifo_state_t;

  jtx_fifo_state_t s_r, s_nxt;
  logic push, load;

  // ----------------------------------------------------------------
  // next state: the output stage refills whenever it is free
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    push = in_valid && (s_r.cnt != FULL);
    load = (s_r.cnt != '0) && (!s_r.ov || out_ready);
    if (s_r.ov && out_ready) begin
      s_nxt.ov = 1'b0;
    end
    if (load) begin
      s_nxt.od = s_r.mem[s_r.rp];
      s_nxt.ov = 1'b1;
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  end

  // the whole state clears on reset, storage included, so no x leaks out
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready = (s_r.cnt != FULL);
  assign out_valid = s_r.ov;
  assign out_data = s_r.od;
endmodule
`default_nettype wire

// [hw/jtx_enc8b10b.sv]
// octet to 10-bit symbol encoder with running disparity
`timescale 1ns/1ps
`default_nettype none
module jtx_enc8b10b (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] data,
  input wire logic k,
  output logic [9:0] symbol
);
  // 6-bit codes for negative running disparity, index EDCBA
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] K4 [8] = '{
    4'hb, 4'h6, 4'ha, 4'hc, 4'hd, 4'h5, 4'h9, 4'h7};
  localparam logic [5:0] K28_6B = 6'h0f;
  localparam logic [5:0] D7_6B = 6'h38;
  localparam logic [3:0] X3_4B = 4'hc;
  localparam logic [3:0] ALT7_4B = 4'h7;

  typedef struct packed {
    logic rd;
    logic [9:0] sym;
  } jtx_enc_state_t;

  jtx_enc_state_t s_r, s_nxt;
  logic [5:0] c6;
  logic [3:0] c4;
  logic rdm, alt;

  // ----------------------------------------------------------------
  // 5b/6b then 3b/4b, each flipped by the disparity before it
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    c6 = k ? K28_6B : T6[data[4:0]];
    if (s_r.rd && (($countones(c6) != 3) || (c6 == D7_6B))) begin
      c6 = ~c6;
    end
    rdm = s_r.rd ^ ($countones(c6) != 3);
    // alternate x.7 avoids a run of five equal bits across the boundary
    alt = !k && (data[7:5] == 3'h7) &&
      ((!rdm && (data[4:0] == 5'h11 || data[4:0] == 5'h12 ||
        data[4:0] == 5'h14)) ||
       (rdm && (data[4:0] == 5'h0b || data[4:0] == 5'h0d ||
        data[4:0] == 5'h0e)));
    c4 = k ? K4[data[7:5]] : (alt ? ALT7_4B : T4[data[7:5]]);
    if (rdm && (k || ($countones(c4) != 2) || (c4 == X3_4B))) begin
      c4 = ~c4;
    end
    s_nxt.rd = rdm ^ ($countones(c4) != 2);
    s_nxt.sym = {c6, c4};
  end

  // running disparity starts negative
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign symbol = s_r.sym;
endmodule
`default_nettype wire

// [bench/jtx_rx_model.sv]
// receiver stand-in: counts commas, fires the timing edge, releases sync
`timescale 1ns/1ps
`default_nettype none
module jtx_rx_model (
  input wire logic clk,
  input wire logic hold,
  input wire logic [7:0] lag,
  input wire logic [9:0] sym,
  output logic sync_n,
  output logic sysref
);
  int run;
  int cnt;
  // ----------------------------------------------------------------
  // sync handshake
  // ----------------------------------------------------------------
  // hold is high from time zero, so both outputs settle low at the
  // first edge while the link is still held in reset
  // lag sets a quick or a slow release after the timing edge
  always @(posedge clk) begin
    if (hold) begin
      sync_n <= 1'b0;
      sysref <= 1'b0;
      run <= 0;
      cnt <= 0;
    end else if (run < 16) begin
      run <= (sym === 10'h0fa || sym === 10'h305) ? run + 1 : 0;
    end else begin
      sysref <= 1'b1;
      cnt <= cnt + 1;
      if (cnt >= int'(lag)) sync_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [bench/test_jtx_link_tx.sv]
// self-checking bench for the single-lane transmit link
`timescale 1ns/1ps
`default_nettype none
module test_jtx_link_tx;
  logic clk, rst, sover, sunder, svalid, sready, sync_n, sysref, scr;
  logic hold, salign;
  logic [13:0] sdata;
  logic [1:0] tail, ilas, phase;
  logic [4:0] k1, lid;
  logic [7:0] did, lag, csum;
  logic [3:0] bid;
  logic [9:0] sym;
  int fails, total_checks, n;
  // rows: scrambler, tail mode, ids, frames minus one, checksum expected
  typedef struct {logic s; logic [1:0] t; logic [7:0] d; logic [3:0] b;
    logic [4:0] l; logic [4:0] k; logic [7:0] c;} jtx_row_t;
  jtx_row_t rows [4] = '{
    '{1'b0, 2'h0, 8'h00, 4'h0, 5'h00, 5'h0b, 8'h2a},
    '{1'b1, 2'h2, 8'ha5, 4'h3, 5'h07, 5'h0f, 8'hdf},
    '{1'b0, 2'h3, 8'hff, 4'hf, 5'h1f, 5'h13, 8'h61},
    '{1'b1, 2'h1, 8'h12, 4'h0, 5'h01, 5'h1f, 8'h52}};

  jtx_link_tx dut (.CLK_SYS(clk), .RESET(rst), .SAMPLE_DATA(sdata),
    .SAMPLE_OVER(sover), .SAMPLE_UNDER(sunder), .SAMPLE_VALID(svalid),
    .SAMPLE_READY(sready), .SYNC_REQUEST_N_INPUT(sync_n), .SYSREF(sysref),
    .SCRAMBLE_EN(scr), .TAIL_MODE(tail), .ILAS_MODE(ilas),
    .FRAMES_PER_MF_M1(k1), .DEVICE_ID(did), .BANK_ID(bid), .LANE_ID(lid),
    .SERIAL_LANE_OUTPUT_PAIR(sym), .LINK_PHASE(phase), .CHECKSUM(csum),
    .SAMPLE_ALIGN(salign));
  jtx_rx_model rx (.clk(clk), .hold(hold), .lag(lag), .sym(sym),
    .sync_n(sync_n), .sysref(sysref));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] kc(input logic [3:0] f);
    return {6'b001111, f};
  endfunction
  // control symbols are matched in either disparity
  function automatic bit isk(input logic [3:0] f);
    return sym === kc(f) || sym === ~kc(f);
  endfunction
  task automatic chk(input string w, input logic [9:0] e, logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkk(input string w, input logic [3:0] f);
    chk(w, kc(f), isk(f) ? kc(f) : sym);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // release sync and wait for the link to leave comma phase, bounded
  task automatic bring_up;
    int a;
    a = 0;
    hold = 1'b0;
    for (int i = 0; i < 3000 && phase === 2'h0; i++) begin
      @(negedge clk);
      if (phase === 2'h0) chkk("comma", 4'ha);
      a += int'(salign === 1'b1);
    end
    chk("align pulses", 10'h1, 10'(a));
  endtask
  task automatic check_ilas(input int k, input logic [1:0] ep);
    for (int i = 1; i <= 8 * k + 1; i++) begin
      @(negedge clk);
      if (i == 2) chkk("ilas start", 4'h4);
      if (i == 2 * k + 1) chkk("mf1 end", 4'h3);
      if (i == 2 * k + 3) chkk("cfg mark", 4'h2);
      if (i == 8 * k) chk("phase after", 10'(ep), 10'(phase));
      if (i == 8 * k + 1) chkk("ilas end", 4'h3);
    end
  endtask
  // one multiframe window once the buffered samples have drained
  task automatic check_repl(input int k);
    int na, nf;
    na = 0;
    nf = 0;
    repeat (2 * k + 80) @(negedge clk);
    repeat (2 * k) begin
      @(negedge clk);
      na += int'(isk(4'h3));
      nf += int'(isk(4'h8));
    end
    chk("mf marks", 10'h1, 10'(na));
    chk("frame marks", 10'(k - 1), 10'(nf));
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // the run needs about 1500 cycles; allow twenty times that
  initial begin
    #600000;
    fails++;
    end_of_test();
  end
  initial begin
    {rst, hold, sover, sunder, svalid, scr} = 6'b110000;
    {sdata, tail, ilas, k1, did, bid, lid, lag} = '0;
    repeat (3) @(negedge clk);
    chk("reset phase", 10'h0, 10'(phase));
    chk("reset sum", 10'h0, 10'(csum));
    rst = 1'b0;
    @(negedge clk);
    chk("first symbol", 10'h0fa, sym);
    $display("reset done");
    // fill while held in sync: 32 words plus the read stage
    sdata = 14'h1555;
    svalid = 1'b1;
    for (n = 0; n < 40 && sready === 1'b1; n++) @(negedge clk);
    chk("depth", 10'(jtx_pkg::FIFO_DEPTH + 1), 10'(n));
    @(negedge clk);
    chk("full refuses", 10'h0, 10'(sready));
    svalid = 1'b0;
    $display("fill done");
    for (int r = 0; r < 4; r++) begin
      // drop sync first: link fields change only while commas go out
      hold = 1'b1;
      repeat (3) @(negedge clk);
      scr = rows[r].s;
      tail = rows[r].t;
      did = rows[r].d;
      bid = rows[r].b;
      lid = rows[r].l;
      k1 = rows[r].k;
      lag = 8'(r * 20);
      repeat (3) @(negedge clk);
      chk("checksum", 10'(rows[r].c), 10'(csum));
      bring_up();
      check_ilas(int'(k1) + 1, 2'h2);
      if (r == 0) check_repl(int'(k1) + 1);
      $display("row %0d done", r);
    end
    hold = 1'b1;
    repeat (2) @(negedge clk);
    chk("resync phase", 10'h0, 10'(phase));
    repeat (2) @(negedge clk);
    chkk("resync comma", 4'ha);
    ilas = 2'h1;
    repeat (4) @(negedge clk);
    bring_up();
    chk("skip align", 10'h2, 10'(phase));
    hold = 1'b1;
    ilas = 2'h2;
    repeat (6) @(negedge clk);
    bring_up();
    check_ilas(int'(k1) + 1, 2'h1);
    $display("mode tests done");
    end_of_test();
  end
endmodule
`default_nettype wire
